// File: rtl/mcs_pkg.sv
// package for the microstep current sequencer: modes, magnitudes, index widths
// assumes magnitudes are per-mille of full winding current
package mcs_pkg;

  typedef enum logic [1:0] {
    MCS_HALF_UNCOMP,
    MCS_HALF_COMP,
    MCS_QUARTER
  } mcs_mode_e;

  // raw mode pin codes
  localparam logic [1:0] MCS_CODE_HALF_UNCOMP = 2'h0;
  localparam logic [1:0] MCS_CODE_HALF_COMP   = 2'h1;
  localparam logic [1:0] MCS_CODE_QUARTER     = 2'h2;

  localparam int unsigned MCS_MAG_W = 10;
  localparam int unsigned MCS_POS_W = 4;
  localparam int unsigned MCS_IDX_W = 3;

  // magnitude in per-mille of full current
  localparam logic [MCS_MAG_W-1:0] MCS_MAG_0    = 10'h000;
  localparam logic [MCS_MAG_W-1:0] MCS_MAG_38_3 = 10'h17f;
  localparam logic [MCS_MAG_W-1:0] MCS_MAG_70_7 = 10'h2c3;
  localparam logic [MCS_MAG_W-1:0] MCS_MAG_92_4 = 10'h39c;
  localparam logic [MCS_MAG_W-1:0] MCS_MAG_100  = 10'h3e8;

  // magnitude index, 0 = 0 deg .. 4 = 90 deg of sine
  localparam logic [MCS_IDX_W-1:0] MCS_IDX_0    = 3'h0;
  localparam logic [MCS_IDX_W-1:0] MCS_IDX_38_3 = 3'h1;
  localparam logic [MCS_IDX_W-1:0] MCS_IDX_70_7 = 3'h2;
  localparam logic [MCS_IDX_W-1:0] MCS_IDX_92_4 = 3'h3;
  localparam logic [MCS_IDX_W-1:0] MCS_IDX_100  = 3'h4;
  localparam logic [MCS_IDX_W-1:0] MCS_IDX_HALF_TURN = 3'h4;

  // quarter-step position steps and landmarks
  localparam logic [MCS_POS_W-1:0] MCS_POS_RESET = 4'h0;
  localparam logic [MCS_POS_W-1:0] MCS_DELTA_Q   = 4'h1;
  localparam logic [MCS_POS_W-1:0] MCS_DELTA_H   = 4'h2;
  localparam logic [MCS_POS_W-1:0] MCS_POS_7     = 4'h7;
  localparam logic [MCS_POS_W-1:0] MCS_POS_8     = 4'h8;
  localparam logic [MCS_POS_W-1:0] MCS_POS_QTR   = 4'h4;

endpackage : mcs_pkg

// File: rtl/mcs_sequencer.sv
// microstep current sequencer: step/direction in, signed phase current references out
// assumes STEP_I, DIR_I, MODE_I are asynchronous pins; regulators sample the outputs
//
// Function
// - at full-step positions only one phase carries current, at 100%, the other is zero.
// - in compensated half step both phases carry 70.7% at odd half-step positions.
// - half-step resolution indexes the cycle as positions 0 to 7, full and half alternating.
// - uncompensated half step switches phases fully on, so both carry full current at odd half-step positions.
// - quarter step splits each full step into four 22.5 degree positions, sixteen per cycle.
// - at quarter position 7 phase A carries 38.3% and phase B 92.4%.
// - at quarter positions 2, 6, 10 and 14 both phases carry 70.7%.
// - phase A has equal magnitude at 1 and 7, and the same reversed at 9 and 15.
// - phase B carries 38.3% at 3, 5, 11, 13, positive at 3 and 13, negative at 5 and 11.
// - the quarter table holds five magnitudes incl. 0% and 100%, signs given per phase.
// - table values keep the resultant current vector at full magnitude.
// - reversing direction walks the position sequence backwards, table untouched.
`timescale 1ns/1ps
`default_nettype none

module mcs_sequencer
  import mcs_pkg::*;
(
  // clock and reset
  input  wire logic                           CLK_I,
  input  wire logic                           RESETN_I,
  // step, direction and mode pins
  input  wire logic                           STEP_I,
  input  wire logic                           DIR_I,
  input  wire logic [1:0]                     MODE_I,
  // current references
  output logic      [mcs_pkg::MCS_MAG_W-1:0]  PHASE_A_MAG_O,
  output logic                                PHASE_A_NEG_O,
  output logic      [mcs_pkg::MCS_MAG_W-1:0]  PHASE_B_MAG_O,
  output logic                                PHASE_B_NEG_O,
  // position in selected resolution
  output logic      [mcs_pkg::MCS_POS_W-1:0]  POS_O
);

  import mcs_pkg::*;

  logic [2:0]           step_sync_r;
  logic [2:0]           dir_sync_r;
  logic [2:0]           mode0_sync_r;
  logic [2:0]           mode1_sync_r;
  logic                 step_lvl_r;
  logic                 dir_lvl_r;
  logic [1:0]           mode_raw_r;
  mcs_mode_e            mode_r;
  mcs_mode_e            mode_nxt;
  logic                 step_evt;
  logic [MCS_POS_W-1:0] pos_r;
  logic [MCS_POS_W-1:0] pos_nxt;
  logic [MCS_POS_W-1:0] delta;
  logic [MCS_IDX_W-1:0] idx_a;
  logic [MCS_IDX_W-1:0] idx_b;
  logic [MCS_MAG_W-1:0] mag_a;
  logic [MCS_MAG_W-1:0] mag_b;

  // sine index of a quarter position: folded into 0..4
  function automatic logic [MCS_IDX_W-1:0] sin_idx(input logic [MCS_POS_W-1:0] p);
    logic [MCS_IDX_W-1:0] m;
    m = p[2:0];
    sin_idx = (m <= MCS_IDX_HALF_TURN) ? m : MCS_IDX_W'(MCS_POS_8 - {1'b0, m});
  endfunction : sin_idx

  // five-entry magnitude table
  function automatic logic [MCS_MAG_W-1:0] mag_of(input logic [MCS_IDX_W-1:0] i);
    case (i)
      MCS_IDX_0:    mag_of = MCS_MAG_0;
      MCS_IDX_38_3: mag_of = MCS_MAG_38_3;
      MCS_IDX_70_7: mag_of = MCS_MAG_70_7;
      MCS_IDX_92_4: mag_of = MCS_MAG_92_4;
      default:      mag_of = MCS_MAG_100;
    endcase
  endfunction : mag_of

  // pin synchronisers, three stages each
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      step_sync_r  <= 3'h0;
      dir_sync_r   <= 3'h0;
      mode0_sync_r <= 3'h0;
      mode1_sync_r <= 3'h0;
    end
    else
    begin
      step_sync_r  <= {step_sync_r[1:0], STEP_I};
      dir_sync_r   <= {dir_sync_r[1:0], DIR_I};
      mode0_sync_r <= {mode0_sync_r[1:0], MODE_I[0]};
      mode1_sync_r <= {mode1_sync_r[1:0], MODE_I[1]};
    end
  end

  // accepted levels: a change counts once stages two and three agree
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      step_lvl_r <= 1'b0;
      dir_lvl_r  <= 1'b0;
      mode_raw_r <= MCS_CODE_HALF_UNCOMP;
    end
    else
    begin
      if (step_sync_r[1] == step_sync_r[2])
        step_lvl_r <= step_sync_r[2];
      if (dir_sync_r[1] == dir_sync_r[2])
        dir_lvl_r <= dir_sync_r[2];
      if (mode0_sync_r[1] == mode0_sync_r[2])
        mode_raw_r[0] <= mode0_sync_r[2];
      if (mode1_sync_r[1] == mode1_sync_r[2])
        mode_raw_r[1] <= mode1_sync_r[2];
    end
  end

  assign step_evt = (step_sync_r[1] == step_sync_r[2]) && step_sync_r[2] && !step_lvl_r;

  // mode decode; an unused code keeps the current mode
  always_comb
  begin
    if (mode_raw_r == MCS_CODE_HALF_UNCOMP)
      mode_nxt = MCS_HALF_UNCOMP;
    else if (mode_raw_r == MCS_CODE_HALF_COMP)
      mode_nxt = MCS_HALF_COMP;
    else if (mode_raw_r == MCS_CODE_QUARTER)
      mode_nxt = MCS_QUARTER;
    else
      mode_nxt = mode_r;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      mode_r <= MCS_HALF_UNCOMP;
    else
      mode_r <= mode_nxt;
  end

  // position kept in sixteenths of a cycle; half modes move two at a time
  assign delta = (mode_r == MCS_QUARTER) ? MCS_DELTA_Q : MCS_DELTA_H;

  always_comb
  begin
    pos_nxt = pos_r;
    if (step_evt)
    begin
      if (dir_lvl_r)
        pos_nxt = pos_r - delta;
      else
        pos_nxt = pos_r + delta;
    end
    if (mode_nxt != MCS_QUARTER)
      pos_nxt[0] = 1'b0;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
      pos_r <= MCS_POS_RESET;
    else
      pos_r <= pos_nxt;
  end

  // phase A follows sine, phase B cosine
  assign idx_a = sin_idx(pos_r);
  assign idx_b = MCS_IDX_W'(MCS_IDX_HALF_TURN - idx_a);

  always_comb
  begin
    mag_a = mag_of(idx_a);
    mag_b = mag_of(idx_b);
    if (mode_r == MCS_HALF_UNCOMP)
    begin
      // unregulated: any energised phase is fully on
      if (idx_a != MCS_IDX_0)
        mag_a = MCS_MAG_100;
      if (idx_b != MCS_IDX_0)
        mag_b = MCS_MAG_100;
    end
  end

  // registered outputs
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      PHASE_A_MAG_O <= MCS_MAG_0;
      PHASE_A_NEG_O <= 1'b0;
      PHASE_B_MAG_O <= MCS_MAG_100;
      PHASE_B_NEG_O <= 1'b0;
      POS_O         <= MCS_POS_RESET;
    end
    else
    begin
      PHASE_A_MAG_O <= mag_a;
      PHASE_A_NEG_O <= pos_r[3] && (idx_a != MCS_IDX_0);
      PHASE_B_MAG_O <= mag_b;
      PHASE_B_NEG_O <= (pos_r > (MCS_POS_8 - MCS_POS_QTR))
                       && (pos_r < (MCS_POS_8 + MCS_POS_QTR));
      POS_O         <= (mode_r == MCS_QUARTER) ? pos_r : {1'b0, pos_r[3:1]};
    end
  end

  // checks
  sequence step_seen_s;
    step_evt && !dir_lvl_r && (mode_r == MCS_QUARTER) && (mode_nxt == MCS_QUARTER);
  endsequence

  sequence pos_up_s;
    pos_r == MCS_POS_W'($past(pos_r) + MCS_DELTA_Q);
  endsequence

  step_advance_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    step_seen_s |=> pos_up_s)
    else $error("quarter step did not advance position by one");

  full_step_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($past(pos_r[1:0]) == 2'h0) |-> ((PHASE_A_MAG_O == MCS_MAG_0) != (PHASE_B_MAG_O == MCS_MAG_0))
      && ((PHASE_A_MAG_O == MCS_MAG_100) || (PHASE_B_MAG_O == MCS_MAG_100)))
    else $error("full-step position not single phase at full current");

  comp_half_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($past(mode_r) == MCS_HALF_COMP && $past(pos_r[1:0]) == 2'h2)
      |-> (PHASE_A_MAG_O == MCS_MAG_70_7) && (PHASE_B_MAG_O == MCS_MAG_70_7))
    else $error("compensated half step not at 70.7 percent");

  uncomp_half_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($past(mode_r) == MCS_HALF_UNCOMP && $past(pos_r[1:0]) == 2'h2)
      |-> (PHASE_A_MAG_O == MCS_MAG_100) && (PHASE_B_MAG_O == MCS_MAG_100))
    else $error("uncompensated half step not fully on");

  pos_seven_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($past(mode_r) == MCS_QUARTER && $past(pos_r) == MCS_POS_7)
      |-> (PHASE_A_MAG_O == MCS_MAG_38_3) && (PHASE_B_MAG_O == MCS_MAG_92_4)
          && !PHASE_A_NEG_O && PHASE_B_NEG_O == 1'b1)
    else $error("position 7 currents wrong");

  phase_b_sign_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($past(pos_r) == 4'h5 || $past(pos_r) == 4'hb) |-> PHASE_B_NEG_O)
    else $error("phase B not negative at 5 or 11");

  phase_a_sign_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    ($past(pos_r) == 4'h9 || $past(pos_r) == 4'hf) |-> PHASE_A_NEG_O
      && (PHASE_A_MAG_O == MCS_MAG_38_3))
    else $error("phase A not reversed 38.3 at 9 or 15");

  half_even_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (mode_r != MCS_QUARTER) |-> (pos_r[0] == 1'b0))
    else $error("half-step mode holds odd sixteenth position");

  reverse_a: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (step_evt && dir_lvl_r && mode_r != MCS_QUARTER && mode_nxt != MCS_QUARTER)
      |=> pos_r == MCS_POS_W'($past(pos_r) - MCS_DELTA_H))
    else $error("reverse half step did not retreat one position");

endmodule : mcs_sequencer

`default_nettype wire

// File: verif/mcs_winding_model.sv
// winding regulator model: turns a signed current reference into a winding current
// assumes references come from the sequencer in the system clock domain
`timescale 1ns/1ps
`default_nettype none

module mcs_winding_model
  import mcs_pkg::*;
(
  // reference
  input  wire logic [mcs_pkg::MCS_MAG_W-1:0] mag_i,
  input  wire logic                          neg_i,
  // winding current in signed per-mille
  output logic signed [mcs_pkg::MCS_MAG_W:0] cur_o
);
  // ideal bridge: the winding follows its reference at once
  always_comb
  begin
    cur_o = neg_i ? -$signed({1'b0, mag_i}) : $signed({1'b0, mag_i});
  end
endmodule : mcs_winding_model
`default_nettype wire

// File: verif/test_microstep_current_sequencer.sv
// testbench for the microstep current sequencer: steps, direction and resolution changes
// assumes outputs settle a few edges after a pin change and hold until the next one
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_microstep_current_sequencer;
  import mcs_pkg::*;
  logic                        clk_i, resetn_i, step_i, dir_i;
  logic [1:0]                  mode_i, mode;
  logic [MCS_MAG_W-1:0]        a_mag, b_mag;
  logic                        a_neg, b_neg;
  logic [MCS_POS_W-1:0]        pos;
  logic signed [MCS_MAG_W:0]   cur_a, cur_b;
  logic [25:0]                 q[$];
  logic [25:0]                 last, cur, exp_b;
  int                          bad_count, checks, p, sq;

  mcs_sequencer i_mcs_sequencer (.CLK_I(clk_i), .RESETN_I(resetn_i), .STEP_I(step_i),
    .DIR_I(dir_i), .MODE_I(mode_i), .PHASE_A_MAG_O(a_mag), .PHASE_A_NEG_O(a_neg),
    .PHASE_B_MAG_O(b_mag), .PHASE_B_NEG_O(b_neg), .POS_O(pos));
  mcs_winding_model i_mcs_winding_model_a (.mag_i(a_mag), .neg_i(a_neg), .cur_o(cur_a));
  mcs_winding_model i_mcs_winding_model_b (.mag_i(b_mag), .neg_i(b_neg), .cur_o(cur_b));

  // expected outputs for a mode code and a position in quarter steps
  function automatic logic [25:0] bund(input logic [1:0] m, input int pp);
    logic [MCS_MAG_W-1:0] tab [5];
    logic [MCS_MAG_W-1:0] ma, mb;
    int                   ka, kb;
    tab = '{MCS_MAG_0, MCS_MAG_38_3, MCS_MAG_70_7, MCS_MAG_92_4, MCS_MAG_100};
    ka = pp % 8;
    kb = (pp + 4) % 8;
    ma = tab[ka > 4 ? 8 - ka : ka];
    mb = tab[kb > 4 ? 8 - kb : kb];
    if (m == MCS_CODE_HALF_UNCOMP)
    begin
      ma = (ma != MCS_MAG_0) ? MCS_MAG_100 : ma;
      mb = (mb != MCS_MAG_0) ? MCS_MAG_100 : mb;
    end
    return {4'(m == MCS_CODE_QUARTER ? pp : pp / 2), ma, 1'(pp > 8), mb,
            1'(pp >= 5 && pp <= 11)};
  endfunction : bund

  // set mode and direction, then optionally one step; expectations go to the queue
  task automatic apply(input logic [1:0] m, input logic d, input bit stp);
    logic [25:0] was;
    was = bund(mode, p);
    @(posedge clk_i);
    #1;
    dir_i = d;
    mode_i = m;
    if (m != 2'h3)
      mode = m;
    if (mode != MCS_CODE_QUARTER)
      p = p & 14;
    if (bund(mode, p) !== was)
      q.push_back(bund(mode, p));
    repeat (6) @(posedge clk_i);
    if (stp)
    begin
      #1;
      step_i = 1'b1;
      p = (p + 16 + (d ? -1 : 1) * (mode == MCS_CODE_QUARTER ? 1 : 2)) % 16;
      q.push_back(bund(mode, p));
      repeat (4) @(posedge clk_i);
      #1;
      step_i = 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask : apply

  task automatic end_of_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // watches the outputs and checks every change against the oldest note
  initial
  begin
    forever
    begin
      @(negedge clk_i);
      cur = {pos, a_mag, a_neg, b_mag, b_neg};
      if (resetn_i === 1'b1 && cur !== last)
      begin
        exp_b = (q.size() > 0) ? q.pop_front() : last;
        `CHK(cur, exp_b)
        sq = cur_a * cur_a + cur_b * cur_b;
        if (mode != MCS_CODE_HALF_UNCOMP)
          `CHK(sq > 998000 && sq < 1002000, 1'b1)
      end
      last = cur;
    end
  end

  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    {resetn_i, step_i, dir_i, mode_i, mode, p, bad_count, checks} = '0;
    void'($urandom(32'h8e92706c));
    repeat (5) @(posedge clk_i);
    #1;
    `CHK({pos, a_mag, a_neg, b_mag, b_neg}, bund(2'h0, 0))
    resetn_i = 1'b1;
    for (int i = 0; i < 9; i++) apply(2'h0, 1'b0, 1'b1);
    for (int i = 0; i < 9; i++) apply(2'h1, 1'b1, 1'b1);
    apply(2'h3, 1'b0, 1'b1);
    for (int i = 0; i < 17; i++) apply(2'h2, 1'b0, 1'b1);
    for (int i = 0; i < 17; i++) apply(2'h2, 1'b1, 1'b1);
    apply(2'h2, 1'b0, 1'b1);
    apply(2'h1, 1'b0, 1'b0);
    for (int i = 0; i < 40; i++)
      apply(2'($urandom_range(3, 0)), 1'($urandom_range(1, 0)), 1'b1);
    repeat (20) @(posedge clk_i);
    `CHK(q.size(), 0)
    end_of_test();
  end
endmodule : test_microstep_current_sequencer
`default_nettype wire
